// *** hw/fifo_reset_control.v ***
// Purpose: 16 x 8 queue with selectable reset behaviour and a Wishbone control port
// Assumes: all inputs synchronous to clk_sys; both queue sides share clk_sys
// Notes: outputs are registered, so reset values show from the edge that samples reset
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
`include "fifo_reset_control_defines.vh"
module fifo_reset_control (
  input  wire        clk_sys,                  // system clock, 25 MHz
  input  wire        rstn,                     // power-up reset, active low
  input  wire        wb_cyc_i,                 // bus cycle
  input  wire        wb_stb_i,                 // bus strobe
  input  wire        wb_we_i,                  // bus write
  input  wire [7:0]  wb_adr_i,                 // byte address
  input  wire [3:0]  wb_sel_i,                 // byte enables
  input  wire [31:0] wb_dat_i,                 // write data
  output reg  [31:0] wb_dat_o,                 // read data
  output reg         wb_ack_o,                 // bus acknowledge
  input  wire        queue_reset,              // edge-sensitive queue reset
  input  wire        common_sync_reset,        // sync reset, both sides
  input  wire        wr_side_reset,            // sync reset, write side
  input  wire        rd_side_reset,            // sync reset, read side
  input  wire        wr_en,                    // write request
  input  wire [7:0]  din,                      // write data
  output reg         full,                     // queue full
  output reg         near_full_flag,           // one slot left
  output reg         threshold_full_flag,      // count at or above threshold
  output reg         wr_ack,                   // write accepted
  output reg         overflow,                 // write while full
  output reg  [4:0]  wr_count,                 // fill count, write side
  input  wire        rd_en,                    // read request
  output reg  [7:0]  dout,                     // read data
  output reg         empty,                    // queue empty
  output reg         near_empty_flag,          // one word left
  output reg         threshold_empty_flag,     // count at or below threshold
  output reg         valid,                    // read data valid
  output reg         underflow,                // read while empty
  output reg  [4:0]  rd_count,                 // fill count, read side
  output reg         corrected_error_flag,     // marked single error on read
  output reg         uncorrectable_error_flag, // marked double error on read
  output reg         reset_busy                // queue in reset state
);

  localparam S_RUN  = 4'b0001;
  localparam S_HOLD = 4'b0010;
  localparam S_SYNC = 4'b0100;
  localparam S_STR  = 4'b1000;

  // register decode, shared by read and write paths
  function [3:0] reg_hit;
    input [5:0] idx;
    begin
      reg_hit = 4'h0;
      case (idx)
        `ADDR_CTRL:     reg_hit = 4'h1;
        `ADDR_DOUT_RST: reg_hit = 4'h2;
        `ADDR_THRESH:   reg_hit = 4'h4;
        `ADDR_STATUS:   reg_hit = 4'h8;
        default:        reg_hit = 4'h0;
      endcase
    end
  endfunction

  reg  [1:0]   rst_sync_q;
  wire         rst_n_s;
  reg  [7:0]   ctrl_q;
  reg  [7:0]   dout_rst_q;
  reg  [4:0]   thr_full_q;
  reg  [4:0]   thr_empty_q;
  reg  [3:0]   state_q;
  reg  [3:0]   state_d;
  reg  [2:0]   cnt_q;
  reg  [2:0]   cnt_d;
  reg          qrst_prev_q;
  reg  [4:0]   wptr_q;
  reg  [4:0]   rptr_q;
  wire [159:0] mem_flat;
  wire [1:0]   mode;
  wire         rst_en;
  wire         hs_low;
  wire         rise;
  wire         in_rst;
  wire         sync_mode;
  wire         common_sync_reset_wr;
  wire         common_sync_reset_rd;
  wire         clr_mem;
  wire         wr_go;
  wire         rd_go;
  wire [4:0]   wptr_d;
  wire [4:0]   rptr_d;
  wire [4:0]   cnt_next;
  wire [9:0]   rd_word;
  wire [3:0]   hit;
  wire         bus_req;

  assign mode      = ctrl_q[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
  assign rst_en    = ctrl_q[`CTRL_RST_EN];
  assign hs_low    = ctrl_q[`CTRL_HS_LOW];
  assign sync_mode = rst_en && (mode == `MODE_SYNC);
  // edge, not level, starts an async reset
  assign rise      = rst_en && !sync_mode && queue_reset && !qrst_prev_q;
  assign in_rst    = (state_q != S_RUN);
  assign common_sync_reset_wr   = sync_mode && (common_sync_reset || wr_side_reset);
  assign common_sync_reset_rd   = sync_mode && (common_sync_reset || rd_side_reset);
  // hard mode keeps storage so the last read word survives
  assign clr_mem   = (rise && mode != `MODE_HARD) || (sync_mode && common_sync_reset);
  assign wr_go     = wr_en && !full && !in_rst && !common_sync_reset_wr;
  assign rd_go     = rd_en && !empty && !in_rst && !common_sync_reset_rd;
  assign wptr_d    = (rise || in_rst || common_sync_reset_wr) ? 5'h00 : wptr_q + {4'h0, wr_go};
  assign rptr_d    = (rise || in_rst || common_sync_reset_rd) ? 5'h00 : rptr_q + {4'h0, rd_go};
  assign cnt_next  = wptr_d - rptr_d;
  assign rd_word   = mem_flat[rptr_q[3:0]*10 +: 10];
  assign hit       = reg_hit(wb_adr_i[7:2]);
  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // power-up reset released through two flops
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n_s = rst_sync_q[1];

  // register writes; one-cycle ack for every address, unmapped reads zero
  always @(posedge clk_sys or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      ctrl_q      <= `CTRL_RESET;
      dout_rst_q  <= `DOUT_RST_RESET;
      thr_full_q  <= `THR_FULL_RESET;
      thr_empty_q <= `THR_EMPTY_RESET;
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req && wb_we_i)
      begin
        if (hit[0] && wb_sel_i[0])
          ctrl_q <= wb_dat_i[7:0];
        if (hit[1] && wb_sel_i[0])
          dout_rst_q <= wb_dat_i[7:0];
        if (hit[2] && wb_sel_i[0])
          thr_full_q <= wb_dat_i[4:0];
        if (hit[2] && wb_sel_i[1])
          thr_empty_q <= wb_dat_i[12:8];
      end
      if (bus_req && !wb_we_i)
      begin
        case (hit)
          4'h1:    wb_dat_o <= {24'h000000, ctrl_q};
          4'h2:    wb_dat_o <= {24'h000000, dout_rst_q};
          4'h4:    wb_dat_o <= {19'h00000, thr_empty_q, 3'h0, thr_full_q};
          4'h8:    wb_dat_o <= {16'h0000, 3'h0, rd_count, 3'h0, reset_busy,
                                empty, full, corrected_error_flag, uncorrectable_error_flag};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // reset sequencer; a new edge restarts the sequence from any state
  always @*
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      S_RUN:
      begin
        state_d = S_RUN;
      end
      S_HOLD:
      begin
        if (!queue_reset)
        begin
          state_d = S_SYNC;
          cnt_d   = `SYNC_CYCLES;
        end
      end
      S_SYNC:
      begin
        if (cnt_q == 3'h1)
          state_d = S_RUN;
        else
          cnt_d = cnt_q - 3'h1;
      end
      S_STR:
      begin
        if (cnt_q != 3'h1)
          cnt_d = cnt_q - 3'h1;
        else if (!queue_reset)
          state_d = S_RUN;
      end
      default:
      begin
        state_d = S_RUN;
        cnt_d   = 3'h0;
      end
    endcase
    if (rise)
    begin
      // full-low mode counts from assertion, so level is not waited for
      if (mode == `MODE_FULL_LOW)
      begin
        state_d = S_SYNC;
        cnt_d   = `SYNC_CYCLES;
      end
      else if (mode == `MODE_HARD)
      begin
        state_d = S_STR;
        cnt_d   = `STRETCH_CYCLES;
      end
      else
      begin
        state_d = S_HOLD;
        cnt_d   = 3'h0;
      end
    end
  end

  // sequencer state and pointers
  always @(posedge clk_sys or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      state_q     <= S_RUN;
      cnt_q       <= 3'h0;
      qrst_prev_q <= 1'b0;
      wptr_q      <= 5'h00;
      rptr_q      <= 5'h00;
    end
    else
    begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      qrst_prev_q <= queue_reset;
      wptr_q      <= wptr_d;
      rptr_q      <= rptr_d;
    end
  end

  // storage words with two error markers each
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_word
      reg [9:0] word_q;
      always @(posedge clk_sys or negedge rst_n_s)
      begin
        if (!rst_n_s)
          word_q <= 10'h000;
        else if (clr_mem)
          word_q <= 10'h000;
        else if (wr_go && wptr_q[3:0] == gi)
          word_q <= {ctrl_q[`CTRL_INJ_DOUBLE], ctrl_q[`CTRL_INJ_SINGLE], din};
      end
      assign mem_flat[gi*10 +: 10] = word_q;
    end
  endgenerate

  // write-side outputs; overflow follows the enable even in reset
  always @(posedge clk_sys or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      full                <= 1'b0;
      near_full_flag      <= 1'b0;
      threshold_full_flag <= 1'b0;
      wr_ack              <= 1'b0;
      overflow            <= 1'b0;
      wr_count            <= 5'h00;
    end
    else
    begin
      overflow <= wr_en && full;
      if (rise || state_d != S_RUN)
      begin
        // full-high mode blocks writers while in reset
        full                <= (mode == `MODE_FULL_HIGH);
        near_full_flag      <= (mode == `MODE_FULL_HIGH);
        threshold_full_flag <= (mode == `MODE_FULL_HIGH);
        wr_ack              <= hs_low;
        wr_count            <= 5'h00;
      end
      else if (common_sync_reset_wr)
      begin
        full                <= 1'b0;
        near_full_flag      <= 1'b0;
        threshold_full_flag <= 1'b0;
        wr_ack              <= hs_low;
        wr_count            <= 5'h00;
      end
      else
      begin
        full                <= (cnt_next == `DEPTH);
        near_full_flag      <= (cnt_next >= `DEPTH - 5'h01);
        threshold_full_flag <= (cnt_next >= thr_full_q);
        wr_ack              <= wr_go ^ hs_low;
        wr_count            <= cnt_next;
      end
    end
  end

  // read-side outputs; data reset value chosen per mode
  always @(posedge clk_sys or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      dout                 <= 8'h00;
      empty                <= 1'b1;
      near_empty_flag      <= 1'b1;
      threshold_empty_flag <= 1'b1;
      valid                <= 1'b0;
      underflow            <= 1'b0;
      rd_count             <= 5'h00;
      reset_busy           <= 1'b0;
    end
    else
    begin
      underflow  <= rd_en && empty;
      reset_busy <= (state_d != S_RUN) || common_sync_reset_wr || common_sync_reset_rd;
      if (rise || state_d != S_RUN)
      begin
        empty                <= 1'b1;
        near_empty_flag      <= 1'b1;
        threshold_empty_flag <= 1'b1;
        valid                <= hs_low;
        rd_count             <= 5'h00;
        if (mode != `MODE_HARD)
          dout <= dout_rst_q;
        else if (ctrl_q[`CTRL_OUT_REG])
          dout <= dout_rst_q;
      end
      else if (common_sync_reset_rd)
      begin
        empty                <= 1'b1;
        near_empty_flag      <= 1'b1;
        threshold_empty_flag <= 1'b1;
        valid                <= hs_low;
        rd_count             <= 5'h00;
        dout                 <= dout_rst_q;
      end
      else
      begin
        empty                <= (cnt_next == 5'h00);
        near_empty_flag      <= (cnt_next <= 5'h01);
        threshold_empty_flag <= (cnt_next <= thr_empty_q);
        valid                <= rd_go ^ hs_low;
        rd_count             <= cnt_next;
        if (rd_go)
          dout <= rd_word[7:0];
      end
    end
  end

  // error markers; in lookahead mode they are kept across resets
  always @(posedge clk_sys or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      corrected_error_flag     <= 1'b0;
      uncorrectable_error_flag <= 1'b0;
    end
    else if (rd_go)
    begin
      corrected_error_flag     <= rd_word[8] && !rd_word[9];
      uncorrectable_error_flag <= rd_word[9];
    end
    else if ((rise || common_sync_reset_rd) && !ctrl_q[`CTRL_LOOKAHEAD])
    begin
      corrected_error_flag     <= 1'b0;
      uncorrectable_error_flag <= 1'b0;
    end
    // lookahead mode: flags stay until the first valid read
  end

endmodule

// *** hw/fifo_reset_control_defines.vh ***
// Purpose: constants for the queue reset controller and its register file
// Assumes: byte addresses on a 32-bit classic Wishbone slave
// Notes: included by fifo_reset_control.v
`ifndef FIFO_RESET_CONTROL_DEFINES_VH
`define FIFO_RESET_CONTROL_DEFINES_VH
`define ADDR_CTRL        6'h00
`define ADDR_DOUT_RST    6'h01
`define ADDR_THRESH      6'h02
`define ADDR_STATUS      6'h03
`define CTRL_MODE_LSB    0
`define CTRL_RST_EN      2
`define CTRL_HS_LOW      3
`define CTRL_OUT_REG     4
`define CTRL_LOOKAHEAD   5
`define CTRL_INJ_SINGLE  6
`define CTRL_INJ_DOUBLE  7
`define CTRL_RESET       8'h04
`define DOUT_RST_RESET   8'h00
`define THR_FULL_RESET   5'h0C
`define THR_EMPTY_RESET  5'h04
`define MODE_FULL_HIGH   2'h0
`define MODE_FULL_LOW    2'h1
`define MODE_HARD        2'h2
`define MODE_SYNC        2'h3
`define SYNC_CYCLES      3'h3
`define STRETCH_CYCLES   3'h5
`define DEPTH            5'h10
`endif

// *** sim/fifo_reset_control_monitor.sv ***
// Purpose: port-level checks of bus handshake and queue reset states
// Assumes: one clock; control word mirrored from accepted bus writes
// Notes: mode-specific checks follow the mirrored mode field
`timescale 1ns/100ps
module fifo_reset_control_monitor (
  input logic        clk_sys,             // system clock
  input logic        rstn,                // reset, active low
  input logic        wb_cyc_i,            // bus cycle
  input logic        wb_stb_i,            // bus strobe
  input logic        wb_we_i,             // bus write
  input logic [7:0]  wb_adr_i,            // byte address
  input logic [3:0]  wb_sel_i,            // byte enables
  input logic [31:0] wb_dat_i,            // write data
  input logic        wb_ack_o,            // bus acknowledge
  input logic        queue_reset,         // queue reset
  input logic        common_sync_reset,   // sync reset
  input logic        wr_side_reset,       // write side reset
  input logic        wr_en,               // write request
  input logic        rd_en,               // read request
  input logic        full,                // queue full
  input logic        near_full_flag,      // one slot left
  input logic        threshold_full_flag, // at or above threshold
  input logic        empty,               // queue empty
  input logic        near_empty_flag,     // one word left
  input logic        wr_ack,              // write accepted
  input logic        overflow,            // write while full
  input logic        underflow,           // read while empty
  input logic [4:0]  wr_count,            // fill count
  input logic [4:0]  rd_count,            // fill count
  input logic [7:0]  dout,                // read data
  input logic        reset_busy           // queue in reset
);
  logic [7:0] ctrl_q;
  wire  [1:0] mode = ctrl_q[1:0];
  wire        rst_on = ctrl_q[2];
  // mirror follows the take edge only, so a held request is not counted twice
  always @(posedge clk_sys or negedge rstn)
    if (!rstn)
      ctrl_q <= 8'h04;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0])
      ctrl_q <= wb_dat_i[7:0];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // reset-recovery steps
  sequence busy3_s;
    (reset_busy && !full)[*3];
  endsequence
  sequence full3_s;
    full[*3];
  endsequence
  ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  underflow_flag_a: assert property (rd_en && empty |=> underflow)
    else $error("read while empty without underflow");
  overflow_flag_a: assert property (wr_en && full |=> overflow)
    else $error("write while full without overflow");
  write_accept_a: assert property (wr_en && !full && !reset_busy && !queue_reset && !ctrl_q[3]
    && !common_sync_reset && !wr_side_reset |=> wr_ack)
    else $error("legal write not acknowledged");
  reset_values_a: assert property ($rose(queue_reset) && rst_on && mode != 2'h3 && !ctrl_q[3]
    |=> empty && near_empty_flag && !wr_ack && wr_count == 5'h00 && rd_count == 5'h00)
    else $error("reset state wrong after queue reset");
  full_high_a: assert property ($rose(queue_reset) && rst_on && mode == 2'h0
    |=> full && near_full_flag && threshold_full_flag)
    else $error("full flags low during full-high reset");
  full_release_a: assert property ($fell(queue_reset) && rst_on && mode == 2'h0 |=> full3_s)
    else $error("full flags dropped before three cycles");
  full_low_a: assert property ($rose(queue_reset) && rst_on && mode == 2'h1
    |=> busy3_s ##1 !reset_busy)
    else $error("full-low reset not three cycles");
  hard_stretch_a: assert property ($rose(queue_reset) && rst_on && mode == 2'h2
    |=> (reset_busy && !full && empty)[*5])
    else $error("hard reset shorter than five cycles");
  hard_dout_a: assert property ($rose(queue_reset) && rst_on && mode == 2'h2 && !ctrl_q[4]
    && !rd_en |=> dout == $past(dout))
    else $error("hard reset changed read data");
  sync_clear_a: assert property (common_sync_reset && rst_on && mode == 2'h3
    |=> empty && !full && !near_full_flag && wr_count == 5'h00)
    else $error("sync reset did not clear queue");
  disabled_a: assert property ($rose(queue_reset) && !rst_on && mode != 2'h3 && !wr_en && !rd_en
    |=> wr_count == $past(wr_count))
    else $error("disabled reset cleared the queue");
endmodule
bind fifo_reset_control fifo_reset_control_monitor mon (.*);

// *** sim/queue_user_model.sv ***
// Purpose: writer and reader logic beside the queue
// Assumes: bench sets want_wr/want_rd; bold breaks the flag gating on purpose
// Notes: gating looks at registered flags, so it lags the queue by one cycle
`timescale 1ns/100ps
module queue_user_model (
  input  logic       clk_sys,           // system clock
  input  logic       want_wr,           // bench asks for writes
  input  logic       want_rd,           // bench asks for reads
  input  logic       bold,              // ignore flags and resets
  input  logic [7:0] wdata,             // byte to send
  input  logic       full,              // queue full
  input  logic       empty,             // queue empty
  input  logic       reset_busy,        // queue in reset
  input  logic       queue_reset,       // queue reset
  input  logic       common_sync_reset, // sync reset
  input  logic       wr_side_reset,     // write side reset
  input  logic       rd_side_reset,     // read side reset
  output logic       wr_en = 1'b0,      // write request
  output logic       rd_en = 1'b0,      // read request
  output logic [7:0] din = 8'h00        // write data
);
  // any reset in progress silences both enables
  wire quiet = reset_busy || queue_reset || common_sync_reset || wr_side_reset || rd_side_reset;
  // enables stay low in reset and when full or empty, unless told to misbehave
  always @(posedge clk_sys)
  begin
    wr_en <= want_wr && (bold || (!full && !quiet));
    rd_en <= want_rd && (bold || (!empty && !quiet));
    din   <= wdata;
  end
endmodule

// *** sim/tb_fifo_reset_control.sv ***
// Purpose: directed scenarios for the queue reset modes
// Assumes: reset held 8 cycles; bus and queue traffic start after release
// Notes: flags are sampled on the falling edge, away from register updates
`timescale 1ns/100ps
module tb_fifo_reset_control;
  logic clk_sys = 1'b0, rstn = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00, din, dout, wdata = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic queue_reset = 1'b0, common_sync_reset = 1'b0, wr_side_reset = 1'b0, rd_side_reset = 1'b0;
  logic want_wr = 1'b0, want_rd = 1'b0, bold = 1'b0, wr_en, rd_en;
  logic full, near_full_flag, threshold_full_flag, wr_ack, overflow, empty, near_empty_flag;
  logic threshold_empty_flag, valid, underflow, corrected_error_flag, uncorrectable_error_flag;
  logic reset_busy;
  logic [4:0] wr_count, rd_count;
  int err_total = 0, cmp_count = 0;
  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;
  fifo_reset_control dut (.*);
  queue_user_model user (.*);
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; request held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    for (n = 0; n < 16 && wb_ack_o !== 1'b1; n++)
      @(posedge clk_sys);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (n == 16)
    begin
      err_total++;
      give_verdict();
    end
  endtask
  // n cycles of requests through the user model; ends settled after the last take
  task automatic op(input logic w, input logic r, input logic f, input int n, input logic [7:0] d);
    @(posedge clk_sys);
    want_wr <= w;
    want_rd <= r;
    bold    <= f;
    wdata   <= d;
    repeat (n) @(posedge clk_sys);
    want_wr <= 1'b0;
    want_rd <= 1'b0;
    bold    <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // single-cycle queue reset; returns just after the edge that saw the rise
  task automatic qpulse();
    @(posedge clk_sys);
    queue_reset <= 1'b1;
    @(posedge clk_sys);
    queue_reset <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic busy_len(input int exp);
    int c;
    c = 0;
    while (reset_busy === 1'b1 && c < 20)
    begin
      c++;
      @(negedge clk_sys);
    end
    chk(c, exp);
    // a reset that never ends is a hang, so stop here
    if (c == 20)
      give_verdict();
  endtask
  task automatic t_powerup();
    @(negedge clk_sys);
    chk({full, near_full_flag, threshold_full_flag, empty, near_empty_flag,
         threshold_empty_flag, valid, wr_ack}, 8'h1C);
    chk({wr_count, rd_count, dout}, 0);
    wb(1'b0, 8'h00, 0);
    chk(q, 32'h04);
    wb(1'b0, 8'h04, 0);
    chk(q, 32'h00);
    wb(1'b0, 8'h08, 0);
    chk(q, 32'h040C);
    wb(1'b0, 8'h0C, 0);
    chk(q, 32'h08);
    wb(1'b0, 8'h40, 0);
    chk(q, 32'h00);
    $display("test powerup done");
  endtask
  task automatic t_full_high();
    wb(1'b1, 8'h04, 32'h5A);
    op(1'b0, 1'b1, 1'b1, 1, 8'h00);
    chk(underflow, 1);
    op(1'b1, 1'b0, 1'b0, 16, 8'h77);
    chk({full, near_full_flag, threshold_full_flag, empty, threshold_empty_flag, wr_count},
        {5'b11100, 5'h10});
    op(1'b1, 1'b0, 1'b1, 1, 8'h78);
    chk(overflow, 1);
    qpulse();
    chk({full, near_full_flag, threshold_full_flag, empty, near_empty_flag}, 5'h1F);
    chk({wr_count, rd_count}, 0);
    chk(dout, 8'h5A);
    repeat (2) @(negedge clk_sys);
    chk(full, 1);
    repeat (6) @(negedge clk_sys);
    chk(full, 0);
    op(1'b1, 1'b0, 1'b0, 1, 8'h3C);
    chk(wr_count, 1);
    $display("test full-high done");
  endtask
  task automatic t_full_low();
    wb(1'b1, 8'h00, 32'h05);
    qpulse();
    chk({full, empty, reset_busy}, 3'b011);
    busy_len(3);
    op(1'b1, 1'b0, 1'b0, 1, 8'h3C);
    chk(wr_count, 1);
    $display("test full-low done");
  endtask
  task automatic t_hard();
    wb(1'b1, 8'h00, 32'h06);
    op(1'b0, 1'b1, 1'b0, 1, 8'h00);
    chk({dout, valid}, {8'h3C, 1'b1});
    qpulse();
    chk({full, empty}, 2'b01);
    chk(dout, 8'h3C);
    busy_len(5);
    op(1'b1, 1'b0, 1'b0, 1, 8'h21);
    chk({wr_count, rd_count}, {5'h01, 5'h01});
    $display("test hard done");
  endtask
  task automatic t_sync();
    wb(1'b1, 8'h00, 32'h07);
    @(posedge clk_sys);
    common_sync_reset <= 1'b1;
    want_wr <= 1'b1;
    bold <= 1'b1;
    @(posedge clk_sys);
    common_sync_reset <= 1'b0;
    want_wr <= 1'b0;
    bold <= 1'b0;
    @(negedge clk_sys);
    chk({empty, near_empty_flag, full, near_full_flag, wr_count}, {4'b1100, 5'h00});
    chk(dout, 8'h5A);
    @(negedge clk_sys);
    chk(wr_count, 1);
    @(posedge clk_sys);
    wr_side_reset <= 1'b1;
    rd_side_reset <= 1'b1;
    @(posedge clk_sys);
    wr_side_reset <= 1'b0;
    rd_side_reset <= 1'b0;
    @(negedge clk_sys);
    chk({rd_count, empty}, 6'h01);
    $display("test sync done");
  endtask
  task automatic t_disabled();
    op(1'b1, 1'b0, 1'b0, 1, 8'h44);
    wb(1'b1, 8'h00, 32'h00);
    qpulse();
    repeat (4) @(negedge clk_sys);
    chk({empty, wr_count}, 6'h01);
    $display("test disabled done");
  endtask
  // active-low handshakes, error markers, lookahead hold, hard output register
  task automatic t_markers();
    wb(1'b1, 8'h00, 32'h0000006D);
    qpulse();
    chk({wr_ack, valid}, 2'b11);
    busy_len(3);
    op(1'b1, 1'b0, 1'b0, 1, 8'h99);
    chk(wr_ack, 1'b0);
    wb(1'b1, 8'h00, 32'h000000AD);
    op(1'b1, 1'b0, 1'b0, 1, 8'h66);
    op(1'b0, 1'b1, 1'b0, 1, 8'h00);
    chk({dout, valid, corrected_error_flag, uncorrectable_error_flag}, {8'h99, 3'b010});
    op(1'b0, 1'b1, 1'b0, 1, 8'h00);
    chk({dout, corrected_error_flag, uncorrectable_error_flag}, {8'h66, 2'b01});
    qpulse();
    chk(uncorrectable_error_flag, 1'b1);
    busy_len(3);
    wb(1'b0, 8'h0C, 32'h00000000);
    chk(q, 32'h00000009);
    wb(1'b1, 8'h00, 32'h00000016);
    qpulse();
    chk(dout, 8'h5A);
    busy_len(5);
    wb(1'b1, 8'h08, 32'h00000301);
    wb(1'b0, 8'h08, 32'h00000000);
    chk(q, 32'h00000301);
    $display("test markers done");
  endtask
  // reset, then every scenario in turn
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_powerup();
    t_full_high();
    t_full_low();
    t_hard();
    t_sync();
    t_disabled();
    t_markers();
    give_verdict();
  end
endmodule
